// File: hw/timer_event_counter_consts.svh
// Constants of the timer/event counter: register indices, byte addresses, field positions, resets, timing.
// Assumes it is included by bare name ahead of the package and the counter module.
`ifndef TIMER_EVENT_COUNTER_CONSTS_SVH
`define TIMER_EVENT_COUNTER_CONSTS_SVH

// Register indices; the byte address of each is four times its index.
`define COUNT_HIGH_INDEX     8'h0f
`define COUNT_LOW_INDEX      8'h10
`define CONTROL_INDEX        8'h11
`define INTERRUPT_INDEX      8'h12
`define COUNT_HIGH_ADDR      (`COUNT_HIGH_INDEX << 2)
`define COUNT_LOW_ADDR       (`COUNT_LOW_INDEX << 2)
`define CONTROL_ADDR         (`CONTROL_INDEX << 2)
`define INTERRUPT_ADDR       (`INTERRUPT_INDEX << 2)

// Field positions.
`define ENABLE_BIT           4
`define EDGE_BIT             3
`define FLAG_BIT             6
`define IRQ_ENABLE_BIT       0

// Reset values.
`define CONTROL_RESET        8'h08
`define COUNT_RESET          16'h0000
`define LOW_BUFFER_RESET     8'h00

// Counter limits for the two builds.
`define COUNT_MAX_WIDE       16'hffff
`define COUNT_MAX_NARROW     16'h00ff

// Instruction clock is the system clock divided by this figure.
`define INSTR_CLOCK_DIVIDE   4
`define PRESCALE_LAST        2'(`INSTR_CLOCK_DIVIDE - 1)

// AXI responses.
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// File: hw/timer_event_counter_pkg.sv
// Types shared by the timer/event counter: modes, measurement states, register layouts.
// Assumes the constants header is compiled first.
`default_nettype none

package timer_event_counter_pkg;

    // Operating mode field of the control register.
    typedef enum logic [1:0] {
        MODE_UNUSED = 2'b00,
        MODE_EVENT  = 2'b01,
        MODE_TIMER  = 2'b10,
        MODE_PULSE  = 2'b11
    } mode_type;

    // Pulse width measurement states.
    typedef enum logic [1:0] {
        PW_ARMED     = 2'b00,
        PW_MEASURING = 2'b01
    } pw_state_type;

    // Layout of the control register.
    typedef struct packed {
        mode_type   mode;
        logic       spare5;
        logic       count_enable_bit;
        logic       edge_select;
        logic [2:0] spare0;
    } control_type;

    // A write request held until both address and data have arrived.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       lane0;
    } write_req_type;

endpackage : timer_event_counter_pkg

`default_nettype wire

// File: hw/timer_event_counter.sv
// Programmable count-up timer/event counter with an AXI4-Lite register slave.
// Assumes one clock aclk, a synchronous active-low reset, and an asynchronous event pin.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "timer_event_counter_consts.svh"
`default_nettype none

// Operation
// - Counter built eight or sixteen bits wide.
// - Clock from event pin or sysclock/4.
// - Wide low write fills buffer only.
// - Wide high write loads preload with buffer.
// - Wide high read latches low; low reads buffer.
// - Narrow: low write preloads, reads live.
// - Mode 01 event, 10 timer, 11 pulse.
// - Event mode pin edges; timer instruction clock.
// - Overflow at max reloads, sets flag.
// - Edge select: 0 rising, 1 falling.
// - Pulse mode measures then clears enable.
// - One pulse measured until re-enabled.
// - Pulse measurement triggered by edges only.
// - Pulse mode overflow reloads and flags too.
// - Counting only while enable bit set.
// - Hardware clears enable only after measurement.
// - Overflow produces a wake-up pulse.
// - Irq enable low blocks interrupt request.
// - Disabled: preload write also loads counter.
// - Enabled: preload write leaves count running.
// - Counter read blocks counting that cycle.
module timer_event_counter
    import timer_event_counter_pkg::*;
#(
    parameter int unsigned COUNT_WIDTH = 16
) (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address channel.
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response channel.
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address channel.
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data channel.
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // External event pin, asynchronous.
    input  wire logic        event_input_pin,
    // Interrupt service.
    input  wire logic        irq_ack,
    output logic             overflow_irq_request,
    output logic             wake_up
);

    localparam bit          WIDE      = (COUNT_WIDTH == 16);
    localparam logic [15:0] COUNT_MAX = WIDE ? `COUNT_MAX_WIDE : `COUNT_MAX_NARROW;

    // Register state.
    control_type   control;
    logic [15:0]   counter;
    logic [15:0]   preload;
    logic [7:0]    low_buffer;
    logic          overflow_flag;
    logic          overflow_irq_enable;

    // Bus state.
    write_req_type write_req;
    logic          aw_held;
    logic          w_held;

    // Timing and pin state.
    logic [1:0]    prescale;
    logic          pin_meta;
    logic          pin_sync;
    logic          pin_prev;
    pw_state_type  pw_state;
    pw_state_type  next_pw_state;

    // Combinational helpers.
    logic          instr_tick;
    logic          rise;
    logic          fall;
    logic          active_edge;
    logic          return_edge;
    logic          aw_take;
    logic          w_take;
    logic          ar_take;
    logic          do_write;
    logic          wr_high;
    logic          wr_low;
    logic          wr_ctrl;
    logic          wr_interrupt_control;
    logic          wr_mapped;
    logic          preload_write;
    logic [15:0]   next_preload;
    logic          count_read;
    logic          raw_step;
    logic          advance;
    logic          overflow;
    logic          pulse_done;
    logic [31:0]   read_value;
    logic          read_mapped;

    // Handshakes: one write and one read at a time, address and data accepted in either order.
    assign awready  = !aw_held && !bvalid;
    assign wready   = !w_held && !bvalid;
    assign arready  = !rvalid;
    assign aw_take  = awvalid && awready;
    assign w_take   = wvalid && wready;
    assign ar_take  = arvalid && arready;
    assign do_write = aw_held && w_held;

    // Capture write address and data as each arrives.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            write_req <= '0;
        end else begin
            if (aw_take) begin
                aw_held        <= 1'b1;
                write_req.addr <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held          <= 1'b1;
                write_req.data  <= wdata[7:0];
                write_req.lane0 <= wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write decode; a write without the low byte lane changes nothing.
    always_comb begin
        wr_high   = 1'b0;
        wr_low    = 1'b0;
        wr_ctrl   = 1'b0;
        wr_interrupt_control   = 1'b0;
        wr_mapped = 1'b1;
        case (write_req.addr)
            `COUNT_HIGH_ADDR: wr_high = do_write && write_req.lane0;
            `COUNT_LOW_ADDR:  wr_low  = do_write && write_req.lane0;
            `CONTROL_ADDR:    wr_ctrl = do_write && write_req.lane0;
            `INTERRUPT_ADDR:  wr_interrupt_control = do_write && write_req.lane0;
            default:          wr_mapped = 1'b0;
        endcase
    end

    // Write response follows the write by one cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Preload write source differs per build: the high byte when wide, the low byte when narrow.
    assign preload_write = WIDE ? wr_high : wr_low;
    assign next_preload  = WIDE ? {write_req.data, low_buffer} : {8'h00, write_req.data};

    // Read value mux; the wide low byte comes only from the buffer, never the live count.
    always_comb begin
        read_value  = 32'h0000_0000;
        read_mapped = 1'b1;
        case (araddr)
            `COUNT_HIGH_ADDR: read_value[7:0] = WIDE ? counter[15:8] : 8'h00;
            `COUNT_LOW_ADDR:  read_value[7:0] = WIDE ? low_buffer : counter[7:0];
            `CONTROL_ADDR:    read_value[7:0] = {control.mode, 1'b0, control.count_enable_bit,
                                                 control.edge_select, 3'b000};
            `INTERRUPT_ADDR: begin
                read_value[`FLAG_BIT]       = overflow_flag;
                read_value[`IRQ_ENABLE_BIT] = overflow_irq_enable;
            end
            default:          read_mapped = 1'b0;
        endcase
    end

    // A read of either count byte stalls counting for that cycle so the bytes agree.
    assign count_read = ar_take && ((araddr == `COUNT_HIGH_ADDR) || (araddr == `COUNT_LOW_ADDR));

    // Read data channel; the answer appears the cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata  <= read_value;
            rresp  <= read_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Low byte buffer: a wide low write fills it, a wide high read latches the live low byte.
    // A write and a latching read in the same cycle resolve in favour of the write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_buffer <= `LOW_BUFFER_RESET;
        end else if (WIDE && wr_low) begin
            low_buffer <= write_req.data;
        end else if (WIDE && ar_take && (araddr == `COUNT_HIGH_ADDR)) begin
            low_buffer <= counter[7:0];
        end
    end

    // Preload register changes only on the preload write of the build.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            preload <= `COUNT_RESET;
        end else if (preload_write) begin
            preload <= next_preload;
        end
    end

    // Instruction clock prescaler: free running, one tick every fourth system clock.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= 2'b00;
        end else begin
            prescale <= prescale + 2'b01;
        end
    end
    assign instr_tick = (prescale == `PRESCALE_LAST);

    // Event pin synchroniser; the edge detector looks only at the second stage and its delay.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= event_input_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end
    assign rise        = pin_sync && !pin_prev;
    assign fall        = !pin_sync && pin_prev;
    assign active_edge = control.edge_select ? fall : rise;
    assign return_edge = control.edge_select ? rise : fall;

    // Pulse measurement: armed waits for the active edge, measuring ends on the return edge.
    // After the end the enable bit is low, so later edges are ignored until software re-arms.
    always_comb begin
        next_pw_state = pw_state;
        pulse_done    = 1'b0;
        case (pw_state)
            PW_ARMED: begin
                if (control.count_enable_bit && (control.mode == MODE_PULSE) && active_edge) begin
                    next_pw_state = PW_MEASURING;
                end
            end
            PW_MEASURING: begin
                if (!control.count_enable_bit || (control.mode != MODE_PULSE)) begin
                    next_pw_state = PW_ARMED;
                end else if (return_edge) begin
                    next_pw_state = PW_ARMED;
                    pulse_done    = 1'b1;
                end
            end
            default: next_pw_state = PW_ARMED;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pw_state <= PW_ARMED;
        end else begin
            pw_state <= next_pw_state;
        end
    end

    // Count source per mode; code 00 never counts.
    always_comb begin
        case (control.mode)
            MODE_EVENT: raw_step = active_edge;
            MODE_TIMER: raw_step = instr_tick;
            MODE_PULSE: raw_step = instr_tick && (pw_state == PW_MEASURING);
            default:    raw_step = 1'b0;
        endcase
    end
    // Steps lost to a read stall are a known small count error for software to allow for.
    assign advance  = raw_step && control.count_enable_bit && !count_read;
    assign overflow = advance && (counter == COUNT_MAX);

    // Counter: loaded by a preload write while stopped, else counts and reloads on overflow.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter <= `COUNT_RESET;
        end else if (preload_write && !control.count_enable_bit) begin
            counter <= next_preload;
        end else if (overflow) begin
            counter <= preload;
        end else if (advance) begin
            counter <= counter + 16'h0001;
        end
    end

    // Control register; a software write wins over the hardware clear at measurement end.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= `CONTROL_RESET;
        end else if (wr_ctrl) begin
            control.mode             <= mode_type'(write_req.data[7:6]);
            control.count_enable_bit <= write_req.data[`ENABLE_BIT];
            control.edge_select      <= write_req.data[`EDGE_BIT];
        end else if (pulse_done) begin
            control.count_enable_bit <= 1'b0;
        end
    end

    // Interrupt control: the overflow flag is sticky and a new overflow wins over any clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag       <= 1'b0;
            overflow_irq_enable <= 1'b0;
        end else begin
            if (wr_interrupt_control) begin
                overflow_irq_enable <= write_req.data[`IRQ_ENABLE_BIT];
            end
            if (overflow) begin
                overflow_flag <= 1'b1;
            end else if (irq_ack) begin
                overflow_flag <= 1'b0;
            end else if (wr_interrupt_control) begin
                overflow_flag <= write_req.data[`FLAG_BIT];
            end
        end
    end

    // Interrupt request is gated by the enable; wake-up is a one-cycle pulse after overflow.
    assign overflow_irq_request = overflow_flag && overflow_irq_enable;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_up <= 1'b0;
        end else begin
            wake_up <= overflow;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_prescale_period: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
        else $error("instruction tick not every fourth clock");
    a_low_keeps_preload: assert property (WIDE && wr_low && !wr_high |=> $stable(preload))
        else $error("low byte write changed preload");
    a_overflow_reload: assert property (overflow && !(preload_write && !control.count_enable_bit)
        |=> (counter == $past(preload)) && overflow_flag)
        else $error("overflow did not reload and flag");
    a_pulse_clears_enable: assert property (pulse_done && !wr_ctrl |=> !control.count_enable_bit)
        else $error("measurement end left enable set");
    a_enable_steady: assert property ((control.mode != MODE_PULSE) && !wr_ctrl
        |=> $stable(control.count_enable_bit))
        else $error("enable changed without software write");
    a_disabled_count_frozen: assert property (!control.count_enable_bit |-> !advance)
        else $error("counter advanced while disabled");
    a_disabled_load: assert property (preload_write && !control.count_enable_bit
        |=> counter == $past(next_preload))
        else $error("stopped counter not loaded by preload write");
    a_enabled_keep: assert property (preload_write && control.count_enable_bit && !advance
        |=> $stable(counter))
        else $error("running counter disturbed by preload write");
    a_read_gate: assert property (count_read |-> !advance)
        else $error("counter advanced during a count read");
    a_irq_gate: assert property (!overflow_irq_enable |-> !overflow_irq_request)
        else $error("interrupt request with enable low");
    a_wake_pulse: assert property (overflow |=> wake_up ##1 (wake_up == $past(overflow)))
        else $error("wake-up does not follow overflow");
    a_flag_sticky: assert property (overflow_flag && !irq_ack && !wr_interrupt_control |=> overflow_flag)
        else $error("overflow flag dropped without clear");

endmodule : timer_event_counter

`default_nettype wire

// File: verification/event_source.sv
// Far-side model: the source of events and pulses on the counter's event pin.
// Assumes the bench calls pulse() right after a rising edge of aclk.
`default_nettype none

module event_source (
    // Clock that times the pulses.
    input  wire logic aclk,
    // Pin toward the counter.
    output var logic  event_input_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // The pin rests low, so the first active rising edge is always a real transition.
    initial begin
        event_input_pin = 1'b0;
    end

    // One high pulse and a low gap; both last at least two clocks so the synchroniser sees them.
    task automatic pulse(input int high_cycles, input int low_cycles);
        event_input_pin <= 1'b1;
        repeat (high_cycles) @(posedge aclk);
        event_input_pin <= 1'b0;
        repeat (low_cycles) @(posedge aclk);
    endtask : pulse
endmodule : event_source

`default_nettype wire

// File: verification/timer_event_counter_bench.sv
// Self-checking bench of the timer/event counter: AXI4-Lite master, register rows, mode tests.
// Assumes the constants header, the package, the design and event_source are compiled first.
`include "timer_event_counter_consts.svh"
`default_nettype none

module timer_event_counter_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk, aresetn, awvalid, wvalid, arvalid, irq_ack;
    logic        awready, wready, bvalid, arready, rvalid, bready, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  bresp, rresp, resp;
    logic        event_input_pin, overflow_irq_request, wake_up;
    logic [15:0] cnt;
    int          n_errors = 0;
    int          num_checks = 0;
    int          n_wake = 0;

    typedef struct {
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  data;
        logic [31:0] exp;
        logic [1:0]  resp;
    } row_type;

    // Register traffic with the counter stopped; the last two rows hit an unmapped word.
    row_type rows [11] = '{
        '{1'b0, `CONTROL_ADDR, 8'h00, 32'h0000_0008, `RESP_OKAY},
        '{1'b0, `INTERRUPT_ADDR, 8'h00, 32'h0000_0000, `RESP_OKAY},
        '{1'b1, `COUNT_LOW_ADDR, 8'h34, 32'h0000_0000, `RESP_OKAY},
        '{1'b0, `COUNT_HIGH_ADDR, 8'h00, 32'h0000_0000, `RESP_OKAY},
        '{1'b0, `COUNT_LOW_ADDR, 8'h00, 32'h0000_0000, `RESP_OKAY},
        '{1'b1, `COUNT_LOW_ADDR, 8'h34, 32'h0000_0000, `RESP_OKAY},
        '{1'b1, `COUNT_HIGH_ADDR, 8'h12, 32'h0000_0000, `RESP_OKAY},
        '{1'b0, `COUNT_HIGH_ADDR, 8'h00, 32'h0000_0012, `RESP_OKAY},
        '{1'b0, `COUNT_LOW_ADDR, 8'h00, 32'h0000_0034, `RESP_OKAY},
        '{1'b1, 8'h80, 8'h55, 32'h0000_0000, `RESP_SLVERR},
        '{1'b0, 8'h80, 8'h00, 32'h0000_0000, `RESP_SLVERR}
    };

    timer_event_counter #(.COUNT_WIDTH(16)) i_timer_event_counter (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'b000), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'b000),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .event_input_pin(event_input_pin), .irq_ack(irq_ack),
        .overflow_irq_request(overflow_irq_request), .wake_up(wake_up)
    );

    event_source i_event_source (.aclk(aclk), .event_input_pin(event_input_pin));

    // Free-running 200 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Wake-up pulses are counted as they pass, since each lasts one cycle only.
    always @(posedge aclk) begin
        if (wake_up === 1'b1) n_wake++;
    end

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check_val

    task automatic check_range(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
        num_checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h to %h", $time, g, lo, hi);
        end
    endtask : check_range

    // Ready is sampled at the rising edge that completes the transfer, and each valid drops right after it.
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            aw_done = aw_done || (awready === 1'b1);
            w_done = w_done || (wready === 1'b1);
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask : axi_read

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        axi_write(a, d, resp);
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
        axi_read(a, got, resp);
        check_val(got, e);
    endtask : rd_check

    // High byte first, so the low byte comes from the same instant of the count.
    task automatic read_count(output logic [15:0] c);
        axi_read(`COUNT_HIGH_ADDR, got, resp);
        c[15:8] = got[7:0];
        axi_read(`COUNT_LOW_ADDR, got, resp);
        c[7:0] = got[7:0];
    endtask : read_count

    task automatic set_count(input logic [15:0] v);
        wr(`COUNT_LOW_ADDR, v[7:0]);
        wr(`COUNT_HIGH_ADDR, v[15:8]);
    endtask : set_count

    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // A hang ends the run here; the tests need under a thousand cycles.
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        summarize();
    end

    initial begin
        {aresetn, awvalid, wvalid, arvalid, irq_ack, awaddr, araddr, wdata} = '0;
        bready = 1'b1;
        rready = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].data, resp);
            end else begin
                axi_read(rows[i].addr, got, resp);
                check_val(got, rows[i].exp);
            end
            check_val({30'h0, resp}, {30'h0, rows[i].resp});
        end
        $display("register rows done");
        // Timer overflow with the interrupt enable low, then high, then acknowledged.
        set_count(16'hfffe);
        n_wake = 0;
        wr(`CONTROL_ADDR, 8'h90);
        repeat (40) @(posedge aclk);
        wr(`CONTROL_ADDR, 8'h80);
        read_count(cnt);
        check_range(cnt, 16'hfffe, 16'hffff);
        rd_check(`INTERRUPT_ADDR, 32'h0000_0040);
        check_val({31'h0, overflow_irq_request}, 32'h0000_0000);
        check_range(16'(n_wake), 16'h0004, 16'h0006);
        wr(`INTERRUPT_ADDR, 8'h41);
        check_val({31'h0, overflow_irq_request}, 32'h0000_0001);
        irq_ack <= 1'b1;
        @(posedge aclk);
        irq_ack <= 1'b0;
        @(posedge aclk);
        check_val({31'h0, overflow_irq_request}, 32'h0000_0000);
        rd_check(`INTERRUPT_ADDR, 32'h0000_0001);
        $display("overflow test done");
        // Timer rate over 400 clocks, with a preload write in mid-run.
        set_count(16'h0000);
        wr(`CONTROL_ADDR, 8'h90);
        repeat (200) @(posedge aclk);
        set_count(16'hf000);
        repeat (190) @(posedge aclk);
        rd_check(`CONTROL_ADDR, 32'h0000_0090);
        wr(`CONTROL_ADDR, 8'h80);
        read_count(cnt);
        check_range(cnt, 16'd95, 16'd105);
        $display("timer test done");
        // Event counting on rising, then falling edges, then the unused mode.
        set_count(16'h0000);
        wr(`CONTROL_ADDR, 8'h50);
        repeat (5) i_event_source.pulse(4, 4);
        wr(`CONTROL_ADDR, 8'h58);
        repeat (3) i_event_source.pulse(4, 4);
        wr(`CONTROL_ADDR, 8'h10);
        repeat (2) i_event_source.pulse(4, 4);
        wr(`CONTROL_ADDR, 8'h40);
        repeat (2) i_event_source.pulse(4, 4);
        read_count(cnt);
        check_val({16'h0, cnt}, 32'h0000_0008);
        $display("event test done");
        // One pulse of 40 clocks is about ten instruction clocks; a second pulse is ignored.
        set_count(16'h0000);
        wr(`CONTROL_ADDR, 8'hd0);
        i_event_source.pulse(40, 8);
        rd_check(`CONTROL_ADDR, 32'h0000_00c0);
        read_count(cnt);
        check_range(cnt, 16'd9, 16'd11);
        i_event_source.pulse(40, 8);
        read_count(cnt);
        check_range(cnt, 16'd9, 16'd11);
        $display("pulse test done");
        // Ten instruction clocks from FFFE overflow five times in pulse mode, each reloading FFFE.
        set_count(16'hfffe);
        wr(`CONTROL_ADDR, 8'hd0);
        i_event_source.pulse(40, 8);
        read_count(cnt);
        check_val({16'h0, cnt}, 32'h0000_fffe);
        rd_check(`INTERRUPT_ADDR, 32'h0000_0041);
        $display("pulse overflow test done");
        // A reset in mid-run stops the counter and restores the control register.
        wr(`CONTROL_ADDR, 8'h90);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_check(`CONTROL_ADDR, 32'h0000_0008);
        read_count(cnt);
        check_val({16'h0, cnt}, 32'h0000_0000);
        $display("reset test done");
        summarize();
    end
endmodule : timer_event_counter_bench

`default_nettype wire
